// ---- verilog/asr_readout.sv ----
// Convert trigger and serial readout sequencing for an 18-bit SAR ADC
//
// Contract
// - 4-wire: the data input, pulled low, is the chip select of a readout.
// - Data input high across the convert_strobe rise picks chip-select mode.
// - Data input low across the convert_strobe rise picks daisy-chain mode.
// - 3-wire: the output drives the MSB once convert_strobe goes low.
// - 3-wire: output released on convert_strobe rise or the last fall.
// - 4-wire: the output drives the MSB once the data input goes low.
// - 4-wire: output released on data input rise or the last fall.
// - Each following result bit appears after each falling shift edge.
// - The current bit stays valid past the fall so the host takes it there.
// - Daisy-chain: the data input is captured on falling shift edges.
// - The busy-indicator 4-wire variant follows the plain sequence.
// - Data input level at each conversion start picks the mode.
`timescale 1ns/1ns
`default_nettype none

module asr_readout (
  input  wire logic              mclk_i,
  input  wire logic              nrst_i,
  input  wire logic              sclk_i,
  input  wire logic              convert_strobe_i,
  input  wire logic              din_i,
  output var  logic              dout_o,
  output var  logic              dout_oe_n_o,
  input  wire logic              result_valid_i,
  input  wire asr_pkg::asr_word_t result_i,
  output var  logic              result_ready_o,
  output var  logic              conv_start_o,
  output var  logic              conv_busy_o,
  output var  logic              daisy_mode_o
);

  localparam int MSB = asr_pkg::RES_BITS - 1;

  // ==========================================================
  // Shift clock domain
  // The shift clock may stop between frames, so this side only
  // records edges; all sequencing lives on the system clock.
  logic srst_s1_r;
  logic srst_s2_r;
  logic fall_tog_r;
  logic din_cap_r;

  // Reset brought into the link domain; needs a few running edges
  always_ff @(negedge sclk_i) begin
    srst_s1_r <= nrst_i;
    srst_s2_r <= srst_s1_r;
  end

  // One toggle per falling edge, data input taken on that edge
  always_ff @(negedge sclk_i) begin
    if (!srst_s2_r) begin
      fall_tog_r <= 1'b0;
      din_cap_r <= 1'b0;
    end else begin
      fall_tog_r <= ~fall_tog_r;
      din_cap_r <= din_i;
    end
  end

  // ==========================================================
  // Pin synchronisers on the system clock
  logic conv_s1_r;
  logic conv_s2_r;
  logic conv_s3_r;
  logic din_s1_r;
  logic din_s2_r;
  logic tog_s1_r;
  logic tog_s2_r;
  logic tog_seen_r;

  // Two flops per pin; third conv flop only feeds the edge detect
  always_ff @(posedge mclk_i) begin
    conv_s1_r <= convert_strobe_i;
    conv_s2_r <= conv_s1_r;
    conv_s3_r <= conv_s2_r;
    din_s1_r <= din_i;
    din_s2_r <= din_s1_r;
    tog_s1_r <= fall_tog_r;
    tog_s2_r <= tog_s1_r;
  end

  // Last toggle value acted on; reset aligns to the live value
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      tog_seen_r <= tog_s2_r;
    end else begin
      tog_seen_r <= tog_s2_r;
    end
  end

  // ==========================================================
  // Event and frame decode
  logic daisy_r;
  asr_pkg::asr_state_t state_r;
  asr_pkg::asr_state_t state_nxt;
  logic [MSB:0] sh_r;
  logic [asr_pkg::BIT_CNT_W-1:0] bit_cnt_r;
  logic oe_n_r;

  wire conv_rise;
  wire fall_evt;
  wire frame_act;
  wire last_fall;
  wire go_load;
  wire go_shift;
  wire go_quit;
  wire shift_in;
  wire buf_valid;
  wire buf_take;
  asr_pkg::asr_word_t buf_word;
  wire [MSB:0] load_word;

  assign conv_rise = conv_s2_r & ~conv_s3_r;
  // Safe: the toggle flop feeds two sync flops before this compare
  assign fall_evt = tog_s2_r ^ tog_seen_r;
  // Daisy frames on convert low; chip-select mode also on data low
  assign frame_act = daisy_r ? ~conv_s2_r
                             : (~conv_s2_r | ~din_s2_r);
  assign last_fall = ~daisy_r && (bit_cnt_r == asr_pkg::LAST_BIT_IDX);
  assign go_load = (state_r == asr_pkg::ST_WAIT) & frame_act & ~conv_rise;
  assign go_shift = (state_r == asr_pkg::ST_SHIFT) & frame_act &
                    ~conv_rise & fall_evt;
  assign go_quit = ~frame_act & ~conv_rise;
  // Daisy: upstream bits follow our own result out of the chain
  assign shift_in = daisy_r & din_cap_r;
  // An empty buffer yields zeros rather than stale data
  assign load_word = buf_valid ? buf_word.code : '0;
  assign buf_take = go_load;

  // ==========================================================
  // Result buffer between the converter core and the shifter
  asr_fifo #(
    .WIDTH (asr_pkg::RES_BITS),
    .DEPTH (asr_pkg::BUF_DEPTH)
  ) u_buf (
    .mclk_i      (mclk_i),
    .nrst_i      (nrst_i),
    .in_valid_i  (result_valid_i),
    .in_data_i   (result_i),
    .in_ready_o  (result_ready_o),
    .out_valid_o (buf_valid),
    .out_data_o  (buf_word),
    .out_ready_i (buf_take)
  );

  // ==========================================================
  // Readout sequencer
  // A new conversion start wins over any frame still open.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      asr_pkg::ST_IDLE: begin
        state_nxt = asr_pkg::ST_IDLE;
      end
      asr_pkg::ST_WAIT: begin
        if (go_load) begin
          state_nxt = asr_pkg::ST_SHIFT;
        end
      end
      asr_pkg::ST_SHIFT: begin
        if (go_quit) begin
          state_nxt = asr_pkg::ST_IDLE;
        end else if (go_shift && last_fall) begin
          state_nxt = asr_pkg::ST_DONE;
        end
      end
      asr_pkg::ST_DONE: begin
        if (go_quit) begin
          state_nxt = asr_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = asr_pkg::ST_IDLE;
      end
    endcase
    if (conv_rise) begin
      state_nxt = asr_pkg::ST_WAIT;
    end
  end

  // State register
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      state_r <= asr_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Mode latched at each conversion start from the data input
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      daisy_r <= asr_pkg::RST_DAISY;
    end else if (conv_rise) begin
      daisy_r <= ~din_s2_r;
    end
  end

  // Output driver enable; low while the pin is driven
  always_ff @(posedge mclk_i) begin
    if (!nrst_i || conv_rise) begin
      oe_n_r <= asr_pkg::RST_OE_N;
    end else if (go_load) begin
      oe_n_r <= 1'b0;
    end else if (state_r == asr_pkg::ST_SHIFT &&
                 (go_quit || (go_shift && last_fall))) begin
      oe_n_r <= 1'b1;
    end
  end

  // Shifter: MSB loaded at frame open, one step per falling edge.
  // Bit changes only on a falling-edge event, so it holds meanwhile.
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      sh_r <= '0;
      bit_cnt_r <= '0;
    end else if (go_load) begin
      sh_r <= load_word;
      bit_cnt_r <= '0;
    end else if (go_shift) begin
      sh_r <= {sh_r[MSB-1:0], shift_in};
      bit_cnt_r <= bit_cnt_r + 1'b1;
    end
  end

  // ==========================================================
  // Conversion trigger and busy window toward the converter core
  logic [asr_pkg::BUSY_CNT_W-1:0] busy_cnt_r;

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      busy_cnt_r <= '0;
      conv_start_o <= 1'b0;
      conv_busy_o <= 1'b0;
    end else begin
      conv_start_o <= conv_rise;
      if (conv_rise) begin
        busy_cnt_r <= asr_pkg::BUSY_CNT_W'(asr_pkg::CONV_MAX_CYC);
      end else if (busy_cnt_r != '0) begin
        busy_cnt_r <= busy_cnt_r - 1'b1;
      end
      conv_busy_o <= conv_rise | (busy_cnt_r > 1);
    end
  end

  // ==========================================================
  // Pin outputs, straight from flops
  assign dout_o = sh_r[MSB];
  assign dout_oe_n_o = oe_n_r;
  assign daisy_mode_o = daisy_r;

  // ==========================================================
  // Checks on the sequencing, all on the system clock
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (!nrst_i);

  a_mode_pick_cs: assert property (
    conv_rise && din_s2_r |=> !daisy_mode_o)
    else $error("data input high at start did not pick chip-select mode");

  // Mode flips on the first cycle, so check the level, not stability
  a_mode_pick_daisy: assert property (
    conv_rise && !din_s2_r |=> daisy_mode_o [*3])
    else $error("data input low at start did not pick daisy-chain mode");

  a_drive_on_open: assert property (
    go_load |=> !dout_oe_n_o && dout_o == $past(load_word[MSB]))
    else $error("serial output not driving the MSB at frame open");

  a_four_wire_cs: assert property (
    state_r == asr_pkg::ST_WAIT && !daisy_r && conv_s2_r && !din_s2_r
      && !conv_rise |=> state_r == asr_pkg::ST_SHIFT)
    else $error("data input low did not open a 4-wire frame");

  a_release_close: assert property (
    state_r == asr_pkg::ST_SHIFT && go_quit |=> dout_oe_n_o
      ##1 dout_oe_n_o)
    else $error("serial output still driven after the frame closed");

  a_release_last: assert property (
    go_shift && last_fall |=> dout_oe_n_o
      && state_r == asr_pkg::ST_DONE)
    else $error("serial output still driven after the last bit");

  a_next_bit: assert property (
    go_shift |=> dout_o == $past(sh_r[MSB-1]))
    else $error("next result bit not presented after falling edge");

  a_bit_holds: assert property (
    state_r == asr_pkg::ST_SHIFT && !fall_evt && !conv_rise
      && !go_quit |=> $stable(dout_o) && !dout_oe_n_o)
    else $error("output bit changed without a falling edge");

  a_daisy_take: assert property (
    go_shift && daisy_r |=> sh_r[0] == $past(din_cap_r))
    else $error("daisy-chain input bit not shifted in");

  a_busy_window: assert property (
    conv_rise |=> conv_start_o && conv_busy_o ##1 conv_busy_o [*8])
    else $error("conversion start did not raise the busy window");

endmodule

`default_nettype wire

// ---- shared/asr_pkg.sv ----
// Shared constants and types for the ADC serial readout block
`default_nettype none

package asr_pkg;

  // ==========================================================
  // Result word
  localparam int RES_BITS = 18;            // Bits per conversion result
  localparam int BIT_CNT_W = 5;            // Width of the shift counter
  localparam logic [BIT_CNT_W-1:0] LAST_BIT_IDX = 5'h11; // 18th fall

  // ==========================================================
  // Timing, in picoseconds so that fractional figures stay exact
  localparam int MCLK_PERIOD_PS = 10000;   // 100 MHz system clock
  localparam int CONV_MAX_PS = 1300000;    // Longest conversion
  localparam int CONV_MIN_PS = 500000;     // Shortest conversion
  localparam int DI_SETUP_PS = 7500;       // Mode level before rising edge
  localparam int DI_HOLD_PS = 0;           // Mode level after rising edge
  // Longest time rounds down, never below one cycle
  localparam int CONV_MAX_CYC = (CONV_MAX_PS / MCLK_PERIOD_PS < 1) ? 1 :
                                CONV_MAX_PS / MCLK_PERIOD_PS;
  localparam int BUSY_CNT_W = 8;           // Holds CONV_MAX_CYC

  // ==========================================================
  // Buffer and reset values
  localparam int BUF_DEPTH = 2;            // Two-entry result buffer
  localparam logic RST_OE_N = 1'b1;        // Serial output released
  localparam logic RST_DAISY = 1'b0;       // Chip-select mode after reset

  // ==========================================================
  // Types
  typedef struct packed {
    logic [RES_BITS-1:0] code;             // Conversion result, MSB first
  } asr_word_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,                      // No readout pending
    ST_WAIT  = 2'b01,                      // Conversion started, frame not open
    ST_SHIFT = 2'b10,                      // Driving result bits
    ST_DONE  = 2'b11                       // All bits out, line released
  } asr_state_t;

endpackage

`default_nettype wire

// ---- verilog/asr_fifo.sv ----
// Two-entry result buffer with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none

module asr_fifo #(
  parameter int WIDTH = asr_pkg::RES_BITS,
  parameter int DEPTH = asr_pkg::BUF_DEPTH
) (
  input  wire logic             mclk_i,
  input  wire logic             nrst_i,
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output var  logic             in_ready_o,
  output var  logic             out_valid_o,
  output logic      [WIDTH-1:0] out_data_o,
  input  wire logic             out_ready_i
);

  localparam int AW = (DEPTH > 2) ? $clog2(DEPTH) : 1;

  // ==========================================================
  // Elaboration checks
  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_cfg
      $error("asr_fifo: DEPTH must be a power of two, two or more");
    end
  endgenerate

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic [AW:0]      cnt_nxt;
  wire              push;
  wire              pop;

  // ==========================================================
  // Handshake decode
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  assign out_data_o = mem_r[rp_r];

  // Pointers and flags; flags registered from the next count
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      in_ready_o <= 1'b0;
      out_valid_o <= 1'b0;
    end else begin
      wp_r <= wp_r + AW'(push);
      rp_r <= rp_r + AW'(pop);
      cnt_r <= cnt_nxt;
      in_ready_o <= (cnt_nxt != (AW+1)'(DEPTH));
      out_valid_o <= (cnt_nxt != '0);
    end
  end

  // Storage needs no reset; it is read only while valid
  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem_r[wp_r] <= in_data_i;
    end
  end

endmodule

`default_nettype wire

// ---- tb/asr_host_model.sv ----
// Host controller model that drives the converter's serial pins
`timescale 1ns/1ns
`default_nettype none

module asr_host_model (
  output var  logic sclk_o,
  output var  logic convert_strobe_o,
  output var  logic din_o,
  input  wire logic dout_i
);
  // ==========================================================
  // Pins idle high; a 180 ns burst spans the reset release, since
  // the link reset needs falls on both sides of it to let go
  initial begin
    sclk_o = 1'b1;
    convert_strobe_o = 1'b1;
    din_o = 1'b1;
    repeat (12) begin
      #8 sclk_o = 1'b0;
      #7 sclk_o = 1'b1;
    end
  end

  // ==========================================================
  // Convert rise with the mode level held well around it
  task automatic conv(input logic chip_sel);
    if (convert_strobe_o) begin
      convert_strobe_o = 1'b0;
      #40;
    end
    din_o = chip_sel;             // Setup 20 ns, hold 20 ns
    #20 convert_strobe_o = 1'b1;  // Shift clock stays high here
    #20;
  endtask

  // Frame open: data input low in 4-wire, else strobe low
  task automatic open_frame(input int mode);
    if (mode == 1)
      din_o = 1'b0;
    else
      convert_strobe_o = 1'b0;
    #60;
  endtask

  // 4-wire frame close by raising the select again
  task automatic close_frame();
    din_o = 1'b1;
    #20;
  endtask

  // Slow enough that the synchronised fall is never lost
  task automatic shift(input int n, input logic [35:0] dbits,
                       input logic chain, output logic [35:0] got);
    got = '0;
    for (int k = 0; k < n; k++) begin
      got[n-1-k] = dout_i;        // Taken 10 ns before the fall, MSB first
      if (chain)
        din_o = dbits[35-k];      // Stands 10 ns before the fall
      #10 sclk_o = 1'b0;
      #30 sclk_o = 1'b1;
      #20;
    end
  endtask
endmodule

`default_nettype wire

// ---- tb/asr_readout_test.sv ----
// Self-checking bench for the ADC serial readout block
`timescale 1ns/1ns
`default_nettype none

module asr_readout_test;
  logic               mclk_i;
  logic               nrst_i;
  logic               result_valid_i;
  asr_pkg::asr_word_t result_i;
  logic               sclk, convert_strobe, din, dout, dout_oe_n;
  logic               result_ready, conv_start, conv_busy, daisy_mode;
  wire logic          dout_w;
  int                 mismatches;
  int                 checks_done;
  logic [31:0]        seed;

  // Released line floats rather than showing the last bit
  assign dout_w = dout_oe_n ? 1'bz : dout;

  asr_readout asr_readout_i (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .sclk_i(sclk), .convert_strobe_i(convert_strobe), .din_i(din),
    .dout_o(dout), .dout_oe_n_o(dout_oe_n),
    .result_valid_i(result_valid_i), .result_i(result_i),
    .result_ready_o(result_ready), .conv_start_o(conv_start),
    .conv_busy_o(conv_busy), .daisy_mode_o(daisy_mode));

  asr_host_model asr_host_model_i (.sclk_o(sclk),
    .convert_strobe_o(convert_strobe), .din_o(din), .dout_i(dout_w));

  // ==========================================================
  // Clock and watchdog
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  initial begin
    #100000;
    mismatches++;
    report_and_stop();
  end

  // ==========================================================
  // Helpers
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Bits seen on the line: word first, chained input after it
  function automatic logic [35:0] expect_bits(input int mode, input int nb,
                                              input logic [17:0] w,
                                              input logic [17:0] c);
    return {w, (mode == 2) ? c : 18'h0} >> (36 - nb);
  endfunction

  task automatic push(input logic [17:0] w);
    int n;
    n = 0;
    @(posedge mclk_i);
    result_valid_i <= 1'b1;
    result_i <= asr_pkg::asr_word_t'(w);
    do begin
      @(posedge mclk_i);
      n++;
    end while (result_ready !== 1'b1 && n < 100);
    if (result_ready !== 1'b1)
      mismatches++;               // Buffer never took the word
    result_valid_i <= 1'b0;
  endtask

  // Conversion start, busy window, mode latch, line released
  task automatic convwait(input logic chip_sel);
    int starts;
    int busy;
    starts = 0;
    busy = 0;
    fork
      asr_host_model_i.conv(chip_sel);
      repeat (200) begin
        @(posedge mclk_i);
        starts += (conv_start === 1'b1);
        busy += (conv_busy === 1'b1);
      end
    join
    chk(36'(starts), 36'h1);
    chk(36'(busy), 36'(asr_pkg::CONV_MAX_CYC));
    chk({35'h0, daisy_mode}, {35'h0, ~chip_sel});
    chk({35'h0, dout_oe_n}, 36'h1);
  endtask

  // One conversion and readout; unless pre is set, the word is
  // queued after the convert rise so a stray early open finds the buffer empty
  task automatic frame(input int mode, input int nb, input bit pre,
                       input logic [17:0] w);
    logic [17:0] c;
    logic [35:0] got;
    logic        rel;
    c = 18'(rnd());
    convwait(mode != 2);
    if (!pre)
      push(w);
    asr_host_model_i.open_frame(mode);
    asr_host_model_i.shift(nb, {c, 18'h0}, mode == 2, got);
    chk(got, expect_bits(mode, nb, w, c));
    if (mode == 1)
      asr_host_model_i.close_frame();
    #60;
    rel = (mode == 1) || (mode == 0 && nb == 18);
    chk({35'h0, dout_oe_n}, {35'h0, rel});
    $display("frame mode %0d bits %0d done", mode, nb);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    logic [17:0] w0;
    logic [17:0] w1;
    int          nb;
    nrst_i = 1'b0;
    result_valid_i = 1'b0;
    result_i = '0;
    seed = 32'h7d7f;
    mismatches = 0;
    checks_done = 0;
    repeat (12) @(posedge mclk_i);
    nrst_i <= 1'b1;
    chk({32'h0, dout_oe_n, conv_busy, daisy_mode, result_ready}, 36'h8);
    repeat (5) @(posedge mclk_i);
    // Select without a conversion is ignored
    asr_host_model_i.open_frame(1);
    chk({35'h0, dout_oe_n}, 36'h1);
    asr_host_model_i.close_frame();
    $display("idle open done");
    // Fill until refused while nobody reads
    w0 = 18'(rnd());
    w1 = 18'h2aaaa;
    push(w0);
    push(w1);
    @(posedge mclk_i);
    result_valid_i <= 1'b1;
    result_i <= asr_pkg::asr_word_t'(18'h15555);
    repeat (5) begin
      @(posedge mclk_i);
      chk({35'h0, result_ready}, 36'h0);
    end
    result_valid_i <= 1'b0;
    $display("buffer fill done");
    // Frames in every mode, with aborts at random bit counts
    for (int i = 0; i < 8; i++) begin
      nb = (i % 3 == 2) ? 36 : ((i == 3 || i == 4) ? 1 + rnd() % 17 : 18);
      frame(i % 3, nb, i < 2, (i == 0) ? w0 : (i == 1) ? w1 : 18'(rnd()));
      if (i == 1)
        chk({35'h0, result_ready}, 36'h1);
    end
    report_and_stop();
  end
endmodule

`default_nettype wire
